// >>> row_refresh_and_repair_modes_tb.sv
// testbench: controller and device joined over the link, driven through apb
`timescale 1ns/1ps
`default_nettype none
module row_refresh_and_repair_modes_tb;
  import rrr_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic [2:0]  trr_bank;
  logic [7:0]  ref_count;
  logic [31:0] seed = 32'h697c1789;
  logic [31:0] q;
  logic [15:0] last_row;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          n_act = 0;
  int          n_pre = 0;
  int          n_trr = 0;
  int          n_rpr = 0;
  rrr_if lnk ();
  // short repair counts keep the run brief
  rrr_ctrl #(.PGM_CNT(20), .PPST_CNT(20)) rrr_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .lnk(lnk));
  rrr_dev rrr_dev_inst (
    .pclk(pclk), .presetn(presetn), .lnk(lnk), .trr_bank(trr_bank), .ref_count(ref_count));
  rrr_checker rrr_checker_inst (
    .pclk(pclk), .presetn(presetn), .cmd(lnk.cmd), .ma(lnk.ma), .op(lnk.op), .ba(lnk.ba),
    .row(lnk.row), .rdata(lnk.rdata), .trr_active(lnk.trr_active),
    .rpr_active(lnk.rpr_active), .ref_credit(lnk.ref_credit));
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (lnk.cmd === RRR_CMD_ACT) begin
      n_act++;
      last_row = lnk.row;
    end
    if (lnk.cmd === RRR_CMD_PRE || lnk.cmd === RRR_CMD_PRECHARGE_ALL_BANKS) n_pre++;
    if (lnk.trr_active === 1'b1) n_trr++;
    if (lnk.rpr_active === 1'b1) n_rpr++;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic give_verdict;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      xfer(1'b0, REG_STATUS, 32'h0);
      k++;
    end while (q[0] !== 1'b0 && k < 200);
    if (k >= 200) begin
      miscompares++;
      give_verdict();
    end
  endtask
  initial begin
    logic [2:0]  b;
    logic [15:0] r;
    logic [7:0]  c0;
    int          a0;
    int          p0;
    int          t0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, REG_STATUS, 32'h0);
    chk("status after reset", 32'h0, q);
    xfer(1'b0, 8'h10, 32'h0);
    chk("unmapped read", 32'h0, q);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      b = 3'(i);
      r = seed[15:0];
      a0 = n_act;
      p0 = n_pre;
      t0 = n_trr;
      c0 = ref_count;
      // last pass sends the unlimited-count code: the device must stay out of the mode
      xfer(1'b1, REG_CFG, {24'h0, (i == 7) ? 4'h8 : {1'b0, seed[18:16]}, 1'b0, b});
      xfer(1'b1, REG_ROW, {16'h0, r});
      xfer(1'b1, REG_CTRL, 32'h1);
      xfer(1'b1, REG_CTRL, 32'h3);
      wait_idle();
      chk("mode seen", (i == 7) ? 32'h0 : 32'h1, 32'(n_trr > t0));
      chk("bank", {29'h0, b}, {29'h0, trr_bank});
      chk("acts", 32'h3, 32'(n_act - a0));
      chk("pres", 32'h3, 32'(n_pre - p0));
      chk("row", {16'h0, r}, {16'h0, last_row});
      chk("credit", {24'h0, c0}, {24'h0, ref_count});
      chk("mode off", 32'h0, {31'h0, lnk.trr_active});
    end
    xfer(1'b1, REG_CTRL, 32'h1);
    xfer(1'b1, REG_CTRL, 32'h4);
    wait_idle();
    p0 = n_pre;
    xfer(1'b1, REG_CTRL, 32'h4);
    wait_idle();
    chk("clear pres", 32'h3, 32'(n_pre - p0));
    chk("mode after abandon", 32'h0, {31'h0, lnk.trr_active});
    a0 = n_act;
    t0 = n_rpr;
    xfer(1'b1, REG_ROW, {16'h0, seed[31:16]});
    xfer(1'b1, REG_CTRL, 32'h2);
    wait_idle();
    chk("repair seen", 32'h1, 32'(n_rpr > t0));
    chk("repair acts", 32'h1, 32'(n_act - a0));
    chk("repair row", {16'h0, seed[31:16]}, {16'h0, last_row});
    chk("repair off", 32'h0, {31'h0, lnk.rpr_active});
    // a repaired die needs a fresh reset before use
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, REG_STATUS, 32'h0);
    chk("status after second reset", 32'h0, q);
    give_verdict();
  end
endmodule // row_refresh_and_repair_modes_tb
`default_nettype wire

// >>> rrr_checker.sv
// checker: timing and mode rules watched on the link between both ends
`timescale 1ns/1ps
`default_nettype none
module rrr_checker (
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // link
  input wire rrr_pkg::rrr_cmd_t cmd,
  input wire logic [5:0]        ma,
  input wire logic [7:0]        op,
  input wire logic [2:0]        ba,
  input wire logic [15:0]       row,
  input wire logic [7:0]        rdata,
  input wire logic              trr_active,
  input wire logic              rpr_active,
  input wire logic              ref_credit
);
  import rrr_pkg::*;
  localparam int D_RAS15 = RAS15_CYC;
  localparam int D_RP    = RP_CYC;
  localparam int D_RAS   = RAS_CYC;
  logic [2:0] bank_r;
  logic [7:0] gap_r;
  logic [1:0] act_r;
  logic [1:0] pre_r;
  wire logic en_w  = cmd == RRR_CMD_MRW && ma == MR_TRR_CFG && op[TRR_EN_BIT];
  wire logic off_w = cmd == RRR_CMD_MRW && ma == MR_TRR_CFG && !op[TRR_EN_BIT];
  wire logic hit_a = trr_active && cmd == RRR_CMD_ACT && ba == bank_r;
  // precharge-all lands on the target bank too
  wire logic hit_p = trr_active && (cmd == RRR_CMD_PRECHARGE_ALL_BANKS || cmd == RRR_CMD_PRE && ba == bank_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_r <= 3'h0;
      act_r  <= 2'h0;
      pre_r  <= 2'h0;
    end else if (en_w) begin
      bank_r <= op[6:4];
      act_r  <= 2'h0;
      pre_r  <= 2'h0;
    end else begin
      act_r <= act_r + 2'(hit_a);
      pre_r <= pre_r + 2'(hit_p);
    end
  end
  // cycles since the last target-bank command; the spacings are least times
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= 8'h00;
    end else if (hit_a || hit_p) begin
      gap_r <= 8'h01;
    end else if (gap_r != 8'hff) begin
      gap_r <= gap_r + 8'h01;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_enter;
    en_w && !trr_active && !(op[2:0] == 3'h0 && op[TRR_UNLIM_BIT]) |=> trr_active;
  endproperty
  a_enter: assert property (p_enter) else $error("mode not entered");
  property p_exit;
    off_w && trr_active |=> !trr_active;
  endproperty
  a_exit: assert property (p_exit) else $error("disable write ignored");
  property p_self;
    hit_p && pre_r == 2'h2 |=> trr_active ##1 trr_active ##1 !trr_active;
  endproperty
  a_self: assert property (p_self) else $error("self clear timing wrong");
  property p_gap;
    en_w |=> cmd == RRR_CMD_NOP;
  endproperty
  a_gap: assert property (p_gap) else $error("command inside mode delay");
  property p_only;
    trr_active |-> cmd inside {RRR_CMD_NOP, RRR_CMD_ACT, RRR_CMD_PRE, RRR_CMD_PRECHARGE_ALL_BANKS} || off_w;
  endproperty
  a_only: assert property (p_only) else $error("illegal command in mode");
  property p_bank;
    trr_active && cmd == RRR_CMD_ACT |-> ba == bank_r;
  endproperty
  a_bank: assert property (p_bank) else $error("other bank activated");
  property p_first;
    hit_p && act_r == 2'h1 |-> gap_r >= D_RAS15;
  endproperty
  a_first: assert property (p_first) else $error("first precharge misplaced");
  property p_ras;
    hit_p && act_r != 2'h1 |-> gap_r >= D_RAS;
  endproperty
  a_ras: assert property (p_ras) else $error("later precharge too early");
  property p_rp;
    hit_a && act_r != 2'h0 |-> gap_r >= D_RP;
  endproperty
  a_rp: assert property (p_rp) else $error("next activate misplaced");
  property p_credit;
    trr_active && cmd inside {RRR_CMD_ACT, RRR_CMD_REF} |-> !ref_credit ##1 !ref_credit;
  endproperty
  a_credit: assert property (p_credit) else $error("credit given in mode");
  property p_res;
    cmd == RRR_CMD_MRR && ma == MR_RPR_RES |=> rdata == RPR_RES_VAL;
  endproperty
  a_res: assert property (p_res) else $error("repair capability wrong");
  property p_rpr;
    cmd == RRR_CMD_MRW && ma == MR_RPR_CTL && op[RPR_EN_BIT] |=> rpr_active;
  endproperty
  a_rpr: assert property (p_rpr) else $error("repair mode not entered");
  property p_quiet;
    rpr_active |-> cmd != RRR_CMD_REF;
  endproperty
  a_quiet: assert property (p_quiet) else $error("refresh during repair");
  c_enter: cover property (en_w ##1 trr_active);
  c_self: cover property (hit_p && pre_r == 2'h2);
  c_rpr: cover property ($rose(rpr_active));
endmodule // rrr_checker
`default_nettype wire

// >>> rrr_ctrl.sv
// controller end: apb registers and sequencer for targeted refresh and row repair
`timescale 1ns/1ps
`default_nettype none
module rrr_ctrl
  import rrr_pkg::*;
#(
  parameter int unsigned PGM_CNT  = PGM_CYC,
  parameter int unsigned PPST_CNT = PPST_CYC
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  rrr_if.ctrl              lnk
);
  import rrr_pkg::*;

  typedef enum logic [3:0] {
    C_IDLE  = 4'h0, C_MRW  = 4'h1, C_WMRD = 4'h2, C_ACT  = 4'h3,
    C_WRAS  = 4'h4, C_PRE  = 4'h5, C_WRP  = 4'h6, C_RPRE = 4'h7,
    C_PGM   = 4'h8, C_EXIT = 4'h9, C_POST = 4'ha, C_CLR  = 4'hb
  } rrr_cst_t;

  typedef struct packed {
    rrr_cst_t      st;
    logic          rpr;
    logic [2:0]    bank;
    logic [2:0]    ba;
    logic [3:0]    mac;
    logic [15:0]   row;
    logic [1:0]    n;
    logic [CNT_W-1:0] cnt;
    rrr_cmd_t      cmd;
    logic [5:0]    ma;
    logic [7:0]    op;
    logic [31:0]   prdata;
    logic          pready;
  } rrr_ctrl_st_t;

  rrr_ctrl_st_t s_r, s_nxt;
  logic acc;

  always_comb begin
    s_nxt = s_r;
    s_nxt.cmd = RRR_CMD_NOP;
    s_nxt.pready = 1'b0;
    acc = psel && penable && !s_r.pready;
    if (acc) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 32'h0;
      if (pwrite) begin
        case (paddr)
          REG_CFG: begin
            s_nxt.bank = pwdata[2:0];
            s_nxt.mac = pwdata[7:4];
          end
          REG_ROW: s_nxt.row = pwdata[15:0];
          REG_CTRL: begin
            if (s_r.st == C_IDLE && pwdata[CTL_GO_TRR]) begin
              s_nxt.st = C_MRW;
              s_nxt.rpr = 1'b0;
            end else if (s_r.st == C_IDLE && pwdata[CTL_GO_RPR]) begin
              s_nxt.st = C_RPRE;
              s_nxt.rpr = 1'b1;
            end else if (s_r.st == C_IDLE && pwdata[CTL_CLR]) begin
              s_nxt.st = C_CLR;
              s_nxt.n = 2'h0;
            end
          end
          default: begin
          end
        endcase
      end else begin
        case (paddr)
          REG_CFG:    s_nxt.prdata = {24'h0, s_r.mac, 1'b0, s_r.bank};
          REG_ROW:    s_nxt.prdata = {16'h0, s_r.row};
          REG_STATUS: s_nxt.prdata = {29'h0, lnk.rpr_active, lnk.trr_active,
                                      s_r.st != C_IDLE};
          default:    s_nxt.prdata = 32'h0;
        endcase
      end
    end
    if (s_r.cnt != '0) s_nxt.cnt = s_r.cnt - 1'b1;
    case (s_r.st)
      C_IDLE: begin
      end
      C_MRW: begin
        s_nxt.cmd = RRR_CMD_MRW;
        s_nxt.ma = s_r.rpr ? MR_RPR_CTL : MR_TRR_CFG;
        // lower nibble carries the activate-limit code unchanged
        s_nxt.op = s_r.rpr ? 8'h10 : {1'b1, s_r.bank, s_r.mac};
        s_nxt.cnt = CNT_W'(MRD_CYC);
        s_nxt.n = 2'h0;
        s_nxt.st = C_WMRD;
      end
      C_WMRD: if (s_r.cnt == '0) s_nxt.st = C_ACT;
      C_ACT: begin
        s_nxt.cmd = RRR_CMD_ACT;
        s_nxt.ba = s_r.bank;
        s_nxt.row = s_r.row;
        s_nxt.st = s_r.rpr ? C_PGM : C_WRAS;
        s_nxt.cnt = s_r.rpr ? CNT_W'(PGM_CNT) :
                    (s_r.n == 2'h0) ? CNT_W'(RAS15_CYC) : CNT_W'(RAS_CYC);
      end
      C_WRAS: if (s_r.cnt == '0) s_nxt.st = C_PRE;
      C_PGM:  if (s_r.cnt == '0) s_nxt.st = C_PRE;
      C_PRE: begin
        s_nxt.cmd = RRR_CMD_PRE;
        s_nxt.ba = s_r.bank;
        s_nxt.n = s_r.n + 2'h1;
        s_nxt.cnt = s_r.rpr ? CNT_W'(PEXIT_CYC) :
                    (s_r.n == 2'h2) ? CNT_W'(RP_CYC + MRD_CYC) : CNT_W'(RP_CYC);
        s_nxt.st = s_r.rpr ? C_EXIT : C_WRP;
      end
      C_WRP: begin
        if (s_r.cnt == '0) s_nxt.st = (s_r.n == 2'h3) ? C_IDLE : C_ACT;
      end
      C_RPRE: begin
        s_nxt.cmd = RRR_CMD_PRECHARGE_ALL_BANKS;
        s_nxt.st = C_MRW;
      end
      C_EXIT: begin
        if (s_r.cnt == '0) begin
          s_nxt.cmd = RRR_CMD_MRW;
          s_nxt.ma = MR_RPR_CTL;
          s_nxt.op = 8'h00;
          s_nxt.cnt = CNT_W'(PPST_CNT);
          s_nxt.st = C_POST;
        end
      end
      C_POST: if (s_r.cnt == '0) s_nxt.st = C_IDLE;
      C_CLR: begin
        if (s_r.cnt == '0) begin
          s_nxt.cmd = (s_r.n == 2'h0) ? RRR_CMD_MRW : RRR_CMD_PRE;
          s_nxt.ma = MR_TRR_CFG;
          s_nxt.op = 8'h00;
          s_nxt.ba = s_r.bank;
          s_nxt.cnt = CNT_W'((s_r.n == 2'h0) ? MRD_CYC : RP_CYC);
          s_nxt.n = s_r.n + 2'h1;
          if (s_r.n == 2'h3) s_nxt.st = C_IDLE;
        end
      end
      default: s_nxt.st = C_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{st: C_IDLE, cmd: RRR_CMD_NOP, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata  = s_r.prdata;
  assign pready  = s_r.pready;
  assign pslverr = 1'b0;
  assign lnk.cmd = s_r.cmd;
  assign lnk.ma  = s_r.ma;
  assign lnk.op  = s_r.op;
  assign lnk.ba  = s_r.ba;
  assign lnk.row = s_r.row;
endmodule : rrr_ctrl
`default_nettype wire

// >>> rrr_dev.sv
// device end: targeted refresh mode tracking and row repair mode registers
`timescale 1ns/1ps
`default_nettype none
module rrr_dev
  import rrr_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // link
  rrr_if.dev        lnk,
  // user side
  output logic [2:0] trr_bank,
  output logic [7:0] ref_count
);
  import rrr_pkg::*;

  typedef struct packed {
    logic [7:0]  cfg;
    logic [7:0]  rpr;
    logic        targeted_row_refresh_mode;
    logic [1:0]  pres;
    logic [1:0]  acts;
    logic        tail;
    logic [7:0]  tcnt;
    logic [7:0]  rdata;
    logic [7:0]  refc;
    logic        credit;
  } rrr_dev_st_t;

  rrr_dev_st_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.credit = 1'b0;
    case (lnk.cmd)
      RRR_CMD_MRW: begin
        if (lnk.ma == MR_TRR_CFG) begin
          s_nxt.cfg = lnk.op;
          if (lnk.op[TRR_EN_BIT] && !(lnk.op[2:0] == 3'h0 && lnk.op[TRR_UNLIM_BIT])) begin
            s_nxt.targeted_row_refresh_mode = 1'b1;
            s_nxt.pres = 2'h0;
            s_nxt.acts = 2'h0;
            s_nxt.tail = 1'b0;
          end else if (!lnk.op[TRR_EN_BIT]) begin
            s_nxt.targeted_row_refresh_mode = 1'b0;
            s_nxt.cfg[6:4] = s_r.cfg[6:4];
          end
        end else if (lnk.ma == MR_RPR_CTL) begin
          s_nxt.rpr = lnk.op;
        end
      end
      RRR_CMD_MRR: begin
        if (lnk.ma == MR_RPR_RES) s_nxt.rdata = RPR_RES_VAL;
        else if (lnk.ma == MR_TRR_CFG) s_nxt.rdata = s_r.cfg;
        else if (lnk.ma == MR_RPR_CTL) s_nxt.rdata = s_r.rpr;
        else s_nxt.rdata = 8'h00;
      end
      RRR_CMD_ACT: begin
        if (s_r.targeted_row_refresh_mode && lnk.ba == s_r.cfg[6:4]) begin
          if (s_r.acts != 2'h3) s_nxt.acts = s_r.acts + 2'h1;
        end else begin
          s_nxt.credit = 1'b0;
        end
      end
      RRR_CMD_PRE,
      RRR_CMD_PRECHARGE_ALL_BANKS: begin
        if (s_r.targeted_row_refresh_mode && (lnk.cmd == RRR_CMD_PRECHARGE_ALL_BANKS || lnk.ba == s_r.cfg[6:4])
            && s_r.pres < s_r.acts) begin
          s_nxt.pres = s_r.pres + 2'h1;
          if (s_r.pres == 2'h2) begin
            s_nxt.tail = 1'b1;
            s_nxt.tcnt = 8'((RP_CYC + MRD_CYC));
          end
        end
      end
      RRR_CMD_REF: begin
        if (!s_r.targeted_row_refresh_mode) begin
          s_nxt.refc = s_r.refc + 8'h01;
          s_nxt.credit = 1'b1;
        end
      end
      default: begin
      end
    endcase
    if (s_r.tail && lnk.cmd != RRR_CMD_MRW) begin
      if (s_r.tcnt <= 8'h01) begin
        s_nxt.targeted_row_refresh_mode = 1'b0;
        s_nxt.tail = 1'b0;
        s_nxt.cfg[TRR_EN_BIT] = 1'b0;
      end else begin
        s_nxt.tcnt = s_r.tcnt - 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{cfg: TRR_CFG_RST, rpr: RPR_CTL_RST, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lnk.rdata      = s_r.rdata;
  assign lnk.trr_active = s_r.targeted_row_refresh_mode;
  assign lnk.rpr_active = s_r.rpr[RPR_EN_BIT];
  assign lnk.ref_credit = s_r.credit;
  assign trr_bank       = s_r.cfg[6:4];
  assign ref_count      = s_r.refc;
endmodule : rrr_dev
`default_nettype wire

// >>> rrr_if.sv
// interface: command/address link between controller and memory device
`timescale 1ns/1ps
`default_nettype none
interface rrr_if;
  rrr_pkg::rrr_cmd_t cmd;
  logic [5:0]        ma;
  logic [7:0]        op;
  logic [2:0]        ba;
  logic [15:0]       row;
  logic [7:0]        rdata;
  logic              trr_active;
  logic              rpr_active;
  logic              ref_credit;
  modport dev  (input cmd, ma, op, ba, row, output rdata, trr_active, rpr_active, ref_credit);
  modport ctrl (output cmd, ma, op, ba, row, input rdata, trr_active, rpr_active, ref_credit);
endinterface : rrr_if
`default_nettype wire

// >>> rrr_pkg.sv
// package: command codes, mode-register layout and timing counts for the row maintenance link
package rrr_pkg;
  localparam int unsigned CLK_MHZ         = 40;
  // times in ns / ms / us as printed or chosen
  localparam int unsigned T_MRD_NS        = 14;
  localparam int unsigned T_RAS_NS        = 42;
  localparam int unsigned T_RP_NS         = 18;
  localparam int unsigned T_PGM_MS        = 1000;
  localparam int unsigned T_PGM_EXIT_NS   = 15;
  localparam int unsigned T_PGMPST_US     = 50;
  // least times round up to whole cycles
  localparam int unsigned MRD_CYC   = (T_MRD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RAS_CYC   = (T_RAS_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RAS15_CYC = (3 * T_RAS_NS * CLK_MHZ + 1999) / 2000;
  localparam int unsigned RP_CYC    = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PGM_CYC   = T_PGM_MS * CLK_MHZ * 1000;
  localparam int unsigned PEXIT_CYC = (T_PGM_EXIT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PPST_CYC  = T_PGMPST_US * CLK_MHZ;
  localparam int unsigned CNT_W     = 32;

  typedef enum logic [2:0] {
    RRR_CMD_NOP  = 3'h0,
    RRR_CMD_MRW  = 3'h1,
    RRR_CMD_ACT  = 3'h2,
    RRR_CMD_PRE  = 3'h3,
    RRR_CMD_PRECHARGE_ALL_BANKS = 3'h4,
    RRR_CMD_REF  = 3'h5,
    RRR_CMD_MRR  = 3'h6
  } rrr_cmd_t;

  // mode-register addresses
  localparam logic [5:0] MR_TRR_CFG = 6'h18;
  localparam logic [5:0] MR_RPR_RES = 6'h19;
  localparam logic [5:0] MR_RPR_CTL = 6'h04;
  // field positions
  localparam int unsigned TRR_EN_BIT    = 7;
  localparam int unsigned TRR_BANK_LSB  = 4;
  localparam int unsigned TRR_UNLIM_BIT = 3;
  localparam int unsigned RPR_EN_BIT    = 4;
  localparam logic [7:0]  TRR_CFG_RST   = 8'h00;
  localparam logic [7:0]  RPR_CTL_RST   = 8'h00;
  localparam logic [7:0]  RPR_RES_VAL   = 8'hff; // one spare row in each of 8 banks
  localparam int unsigned TRR_STEPS     = 3;

  // controller register offsets (apb, one word each)
  localparam logic [7:0] REG_CTRL   = 8'h00; // [0] go trr, [1] go repair, [2] clear trr
  localparam logic [7:0] REG_CFG    = 8'h04; // [2:0] bank, [7:4] mac limit field
  localparam logic [7:0] REG_ROW    = 8'h08; // [15:0] failed or target row
  localparam logic [7:0] REG_STATUS = 8'h0c; // [0] busy, [1] device trr, [2] device repair
  localparam int unsigned CTL_GO_TRR = 0;
  localparam int unsigned CTL_GO_RPR = 1;
  localparam int unsigned CTL_CLR    = 2;
endpackage : rrr_pkg
